// [bench/drs_power_stage.sv]
// Model of the external supplies and power stage beside the selector.
`timescale 1ns/10ps
module drs_power_stage #(
  parameter int unsigned SETTLE = 3
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic low_voltage_enable_i,
  input wire logic amp_enable_i,
  input wire logic [14:0] battery_set_i,
  output logic [14:0] battery_voltage_o,
  output logic on_battery_o
);
  logic [7:0] age;
  // The rail only moves after the switch settles, so short glitches vanish.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      age <= 8'h00;
      battery_voltage_o <= 15'h0000;
      on_battery_o <= 1'b0;
    end else begin
      battery_voltage_o <= battery_set_i;
      age <= (low_voltage_enable_i == on_battery_o || !amp_enable_i) ? 8'h00
        : age + 8'h01;
      if (age == 8'(SETTLE)) on_battery_o <= low_voltage_enable_i;
    end
  end
endmodule // drs_power_stage

// [bench/drs_rail_checker.sv]
// Concurrent checks of rail choice, audio timing and bus answers.
`timescale 1ns/10ps
module drs_rail_checker (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic sample_valid_i,
  input wire logic signed [15:0] sample_i,
  input wire logic [14:0] battery_voltage_i,
  input wire logic out_valid_o,
  input wire logic signed [15:0] out_sample_o,
  input wire logic low_voltage_enable_out_o,
  input wire logic amp_enable_o
);
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] ctrl_sh, thr_sh, bat_sh, tim_sh;
  logic [16:0] below_cnt;
  logic [15:0] mag;
  logic [14:0] lvl, rel_thr, thr;
  logic auto_on, above, lv;
  assign lv = low_voltage_enable_out_o;
  assign mag = sample_i[15] ? -sample_i : sample_i;
  assign lvl = mag[15] ? 15'h7fff : mag[14:0];
  assign rel_thr = battery_voltage_i - thr_sh[30:16];
  assign auto_on = ctrl_sh[5:4] == drs_pkg::MODE_AUTO && !ctrl_sh[1];
  assign above = lvl > thr;
  always_comb begin
    thr = rel_thr;
    if (ctrl_sh[9:8] == drs_pkg::METH_FIXED) begin
      thr = thr_sh[14:0];
    end else if (ctrl_sh[9:8] == drs_pkg::METH_MIN &&
        thr_sh[14:0] < rel_thr) begin
      thr = thr_sh[14:0];
    end
  end
  // Shadow copies of the written registers, so rules can be judged from pins.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      ctrl_sh <= {22'h0, drs_pkg::METH_RST, 2'h0, drs_pkg::MODE_RST, 4'h0};
      thr_sh <= {1'b0, drs_pkg::HEADROOM_RST, 1'b0, drs_pkg::FIXED_THR_RST};
      bat_sh <= {17'h0, drs_pkg::BATT_LOW_RST};
      tim_sh <= {11'h0, drs_pkg::DELAY_RST, drs_pkg::HOLD_RST};
      below_cnt <= 17'h0;
    end else begin
      wr_pend <= hsel_i && hready_i && htrans_i == drs_pkg::HTRANS_NONSEQ
        && hwrite_i && hsize_i == drs_pkg::HSIZE_WORD;
      wr_addr <= haddr_i;
      if (wr_pend && wr_addr == drs_pkg::ADDR_CTRL) ctrl_sh <= hwdata_i;
      if (wr_pend && wr_addr == drs_pkg::ADDR_THRESH) thr_sh <= hwdata_i;
      if (wr_pend && wr_addr == drs_pkg::ADDR_BATT) bat_sh <= hwdata_i;
      if (wr_pend && wr_addr == drs_pkg::ADDR_TIMING) tim_sh <= hwdata_i;
      if (sample_valid_i && ctrl_sh[0] && auto_on) begin
        below_cnt <= above ? 17'h0 : below_cnt + 17'h1;
      end
    end
  end
  ready_okay_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    hreadyout_o && !hresp_o) else $error("bus answer not ready or not okay");
  amp_follow_a: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    ##1 amp_enable_o == $past(ctrl_sh[0])) else $error("amp enable wrong");
  fixed_high_a: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (ctrl_sh[1] || ctrl_sh[4])[*2] |=> !lv) else $error("high rail not held");
  fixed_batt_a: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (!ctrl_sh[1] && ctrl_sh[5:4] == drs_pkg::MODE_BATT)[*2] |=> lv)
    else $error("battery rail not held");
  batt_low_a: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (auto_on && battery_voltage_i < bat_sh[14:0])[*2] |=> !lv)
    else $error("low battery did not force high rail");
  bypass_timing_a: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    sample_valid_i && ctrl_sh[0] && ctrl_sh[5:4] != drs_pkg::MODE_AUTO |->
    ##2 out_valid_o && out_sample_o == $past(sample_i, 2))
    else $error("undelayed sample late or wrong");
  above_high_a: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    sample_valid_i && ctrl_sh[0] && auto_on && above |-> ##2 !lv)
    else $error("loud sample left battery rail on");
  hold_min_a: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    $rose(lv) && auto_on |-> below_cnt > {1'b0, tim_sh[15:0]})
    else $error("battery rail chosen before hold time");
endmodule // drs_rail_checker

bind drs_rail_selector drs_rail_checker chk (.clock_i, .resetn_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i,
  .hreadyout_o, .hresp_o, .sample_valid_i, .sample_i, .battery_voltage_i,
  .out_valid_o, .out_sample_o, .low_voltage_enable_out_o, .amp_enable_o);

// [bench/drs_rail_selector_bench.sv]
// Self-checking bench of the rail selector: registers, rails, audio delay.
`timescale 1ns/10ps
module drs_rail_selector_bench;
  logic clock_i, resetn_i, hsel_i, hwrite_i, sample_valid_i;
  logic [7:0] haddr_i;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic [31:0] hwdata_i, hrdata_o, rd;
  logic hreadyout_o, hresp_o, out_valid_o, lv_o, amp_o, on_batt;
  logic signed [15:0] sample_i, out_sample_o;
  logic [14:0] batt_set, batt_v;
  logic signed [15:0] outq[$];
  logic [39:0] mtab[8] = '{40'h0_1800_1200_0, 40'h1_1800_1200_1,
    40'h1_1800_1600_0, 40'h1_1c00_1600_1, 40'h2_1800_1200_0,
    40'h2_1c00_0f00_1, 40'h2_1200_0f00_0, 40'h2_1200_0d00_1};
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  drs_rail_selector uut (.clock_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
    .hreadyout_o, .hresp_o, .sample_valid_i, .sample_i,
    .battery_voltage_i(batt_v), .out_valid_o, .out_sample_o,
    .low_voltage_enable_out_o(lv_o), .amp_enable_o(amp_o));
  drs_power_stage stage (.clock_i, .resetn_i, .low_voltage_enable_i(lv_o),
    .amp_enable_i(amp_o), .battery_set_i(batt_set),
    .battery_voltage_o(batt_v), .on_battery_o(on_batt));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // The whole run takes a few hundred cycles; far beyond that is a hang.
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (out_valid_o === 1'b1) outq.push_back(out_sample_o);
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    hsel_i <= 1'b1;
    htrans_i <= drs_pkg::HTRANS_NONSEQ;
    haddr_i <= a;
    hwrite_i <= wr;
    @(posedge clock_i);
    while (hreadyout_o !== 1'b1) @(posedge clock_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    @(posedge clock_i);
    while (hreadyout_o !== 1'b1) @(posedge clock_i);
    rd = hrdata_o;
  endtask

  task automatic rchk(input string what, input logic [7:0] a,
      input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask

  function automatic logic [31:0] ctrl(input logic en, nb,
      input logic [1:0] md, mt);
    return {22'h0, mt, 2'h0, md, 2'h0, nb, en};
  endfunction

  task automatic send(input logic signed [15:0] s);
    sample_valid_i <= 1'b1;
    sample_i <= s;
    @(posedge clock_i);
    sample_valid_i <= 1'b0;
    tick(4);
  endtask

  // A loud sample first, so every hold count starts from a known point.
  task automatic go_batt();
    send(16'sh7000);
    send(16'sh0010);
    send(-16'sh0010);
    send(16'sh0010);
    send(-16'sh0010);
  endtask

  initial begin
    resetn_i = 1'b0;
    hsel_i = 1'b0;
    haddr_i = 8'h00;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = drs_pkg::HSIZE_WORD;
    hwdata_i = 32'h0;
    sample_valid_i = 1'b0;
    sample_i = 16'sh0000;
    batt_set = 15'h3000;
    tick(8);
    resetn_i <= 1'b1;
    tick(1);
    rchk("ctrl", drs_pkg::ADDR_CTRL, ctrl(1'b0, 1'b0, drs_pkg::MODE_RST,
      drs_pkg::METH_RST));
    rchk("thresh", drs_pkg::ADDR_THRESH, {1'b0, drs_pkg::HEADROOM_RST, 1'b0,
      drs_pkg::FIXED_THR_RST});
    rchk("timing", drs_pkg::ADDR_TIMING, {11'h0, drs_pkg::DELAY_RST,
      drs_pkg::HOLD_RST});
    bus(1'b1, 8'h40, 32'hffff_ffff);
    rchk("unmapped", 8'h40, 32'h0);
    $display("test reset_values done");

    bus(1'b1, drs_pkg::ADDR_CTRL, ctrl(1'b1, 1'b0, drs_pkg::MODE_HIGH, 2'h0));
    tick(2);
    check("amp on", 32'h1, 32'(amp_o));
    outq.delete();
    send(16'sh1234);
    check("bypass", 32'(16'sh1234), 32'(outq[0]));
    bus(1'b1, drs_pkg::ADDR_CTRL, ctrl(1'b0, 1'b0, drs_pkg::MODE_HIGH, 2'h0));
    send(16'sh0222);
    tick(2);
    check("amp off", 32'h0, 32'(amp_o));
    check("dropped", 32'h1, 32'(outq.size()));
    $display("test enable done");

    // Unassigned mode 3 must fall back to the high-voltage rail.
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, drs_pkg::ADDR_CTRL, ctrl(1'b1, i == 3, i == 0 ?
        drs_pkg::MODE_HIGH : i == 2 ? 2'h3 : drs_pkg::MODE_BATT,
        drs_pkg::METH_FIXED));
      send(16'sh7000);
      send(16'sh0000);
      tick(4);
      check("fixed lv", 32'(i == 1), 32'(lv_o));
      check("stage rail", 32'(i == 1), 32'(on_batt));
    end
    $display("test fixed_modes done");

    bus(1'b1, drs_pkg::ADDR_THRESH, {1'b0, 15'h0400, 1'b0, 15'h1000});
    bus(1'b1, drs_pkg::ADDR_TIMING, 32'h0000_0002);
    bus(1'b1, drs_pkg::ADDR_CTRL, ctrl(1'b1, 1'b0, drs_pkg::MODE_AUTO, 2'h0));
    send(16'sh1800);
    repeat (5) send(16'sh0100);
    check("no crossing", 32'h0, 32'(lv_o));
    send(16'sh1800);
    send(16'sh0100);
    send(16'sh0000);
    check("run broken", 32'h0, 32'(lv_o));
    send(-16'sh0100);
    send(16'sh0100);
    check("battery rail", 32'h1, 32'(lv_o));
    rchk("status", drs_pkg::ADDR_STATUS, 32'h0000_0007);
    check("stage battery", 32'h1, 32'(on_batt));
    send(16'sh8000);
    check("loud sample", 32'h0, 32'(lv_o));
    repeat (3) send(16'sh0100);
    send(16'sh0000);
    check("zero sample", 32'h1, 32'(lv_o));
    $display("test hold_and_crossing done");

    bus(1'b1, drs_pkg::ADDR_TIMING, 32'h0000_0000);
    bus(1'b1, drs_pkg::ADDR_BATT, 32'h0000_0800);
    for (int i = 0; i < 8; i++) begin
      batt_set <= mtab[i][34:20];
      bus(1'b1, drs_pkg::ADDR_CTRL, ctrl(1'b1, 1'b0, drs_pkg::MODE_AUTO,
        mtab[i][37:36]));
      go_batt();
      send(mtab[i][19:4]);
      check("method lv", 32'(mtab[i][0]), 32'(lv_o));
    end
    batt_set <= 15'h0400;
    tick(6);
    check("battery low", 32'h0, 32'(lv_o));
    batt_set <= 15'h3000;
    $display("test thresholds done");

    bus(1'b1, drs_pkg::ADDR_TIMING, {11'h0, 5'h03, 16'h0000});
    tick(2);
    outq.delete();
    for (int k = 0; k < 6; k++) send(16'(k * 16'h0101));
    for (int k = 0; k < 3; k++) begin
      check("delayed", 32'(k * 16'h0101), 32'(outq[k + 3]));
    end
    $display("test signal_delay done");
    tally_and_finish();
  end
endmodule // drs_rail_selector_bench

// [rtl/drs_ahb_regs.sv]
// AHB-Lite register slave holding configuration and showing status.
`timescale 1ns/10ps
module drs_ahb_regs (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [3:0] status_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output drs_pkg::drs_cfg_t cfg_o
);
  drs_pkg::drs_cfg_t cfg_reg;
  drs_pkg::drs_cfg_t cfg_next;
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic take;

  function automatic logic [31:0] read_word(input logic [7:0] a,
      input drs_pkg::drs_cfg_t c, input logic [3:0] st);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      drs_pkg::ADDR_CTRL: begin
        w[drs_pkg::CTRL_PATH_EN] = c.speaker_path_enable;
        w[drs_pkg::CTRL_NOBATT] = c.no_battery_supply;
        w[drs_pkg::CTRL_MODE_LO +: 2] = c.amp_supply_mode;
        w[drs_pkg::CTRL_METH_LO +: 2] = c.switch_threshold_method;
      end
      drs_pkg::ADDR_THRESH: begin
        w = {1'b0, c.battery_relative_headroom, 1'b0,
             c.fixed_switch_threshold};
      end
      drs_pkg::ADDR_BATT: w[14:0] = c.battery_low_level;
      drs_pkg::ADDR_TIMING: begin
        w = {11'h000, c.signal_path_delay, c.low_rail_hold_time};
      end
      drs_pkg::ADDR_STATUS: w[3:0] = st;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  assign take = hsel_i && hready_i && (htrans_i == drs_pkg::HTRANS_NONSEQ);

  always_comb begin
    cfg_next = cfg_reg;
    wr_pend_next = take && hwrite_i && (hsize_i == drs_pkg::HSIZE_WORD);
    addr_next = take ? haddr_i : addr_reg;
    rdata_next = rdata_reg;
    if (take && !hwrite_i) begin
      rdata_next = read_word(haddr_i, cfg_reg, status_i);
    end
    if (wr_pend_reg) begin
      case (addr_reg)
        drs_pkg::ADDR_CTRL: begin
          cfg_next.speaker_path_enable = hwdata_i[drs_pkg::CTRL_PATH_EN];
          cfg_next.no_battery_supply = hwdata_i[drs_pkg::CTRL_NOBATT];
          cfg_next.amp_supply_mode = hwdata_i[drs_pkg::CTRL_MODE_LO +: 2];
          cfg_next.switch_threshold_method =
            hwdata_i[drs_pkg::CTRL_METH_LO +: 2];
        end
        drs_pkg::ADDR_THRESH: begin
          cfg_next.fixed_switch_threshold = hwdata_i[14:0];
          cfg_next.battery_relative_headroom = hwdata_i[30:16];
        end
        drs_pkg::ADDR_BATT: cfg_next.battery_low_level = hwdata_i[14:0];
        drs_pkg::ADDR_TIMING: begin
          cfg_next.low_rail_hold_time = hwdata_i[15:0];
          cfg_next.signal_path_delay = hwdata_i[20:16];
        end
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_reg.speaker_path_enable <= 1'b0;
      cfg_reg.no_battery_supply <= 1'b0;
      cfg_reg.amp_supply_mode <= drs_pkg::MODE_RST; // (R5)
      cfg_reg.switch_threshold_method <= drs_pkg::METH_RST;
      cfg_reg.fixed_switch_threshold <= drs_pkg::FIXED_THR_RST;
      cfg_reg.battery_relative_headroom <= drs_pkg::HEADROOM_RST;
      cfg_reg.battery_low_level <= drs_pkg::BATT_LOW_RST;
      cfg_reg.low_rail_hold_time <= drs_pkg::HOLD_RST;
      cfg_reg.signal_path_delay <= drs_pkg::DELAY_RST;
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      cfg_reg <= cfg_next;
      wr_pend_reg <= wr_pend_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
    end
  end

  // Zero wait states: every transfer completes in its first data cycle.
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_reg;
  assign cfg_o = cfg_reg;
endmodule // drs_ahb_regs

// [rtl/drs_delay_line.sv]
// Programmable sample delay line for the audio path.
`timescale 1ns/10ps
module drs_delay_line #(
  parameter int unsigned DEPTH = drs_pkg::DELAY_MAX
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [4:0] delay_i,
  input wire drs_pkg::drs_sample_t in_i,
  output drs_pkg::drs_sample_t out_o
);
  // The 5-bit pointer wraps only at 32 entries, so no other depth works.
  if (DEPTH != 32) begin : g_depth_check
    $error("drs_delay_line: DEPTH must be 32");
  end

  logic signed [15:0] mem_reg [DEPTH];
  logic signed [15:0] mem_next [DEPTH];
  logic [4:0] wptr_reg;
  logic [4:0] wptr_next;
  drs_pkg::drs_sample_t out_reg;
  drs_pkg::drs_sample_t out_next;

  always_comb begin
    mem_next = mem_reg;
    wptr_next = wptr_reg;
    out_next = out_reg;
    out_next.valid = 1'b0;
    if (in_i.valid) begin
      mem_next[wptr_reg] = in_i.data;
      wptr_next = wptr_reg + 5'h01;
      out_next.valid = 1'b1;
      // A zero delay bypasses the store so no sample is held back.
      if (delay_i == 5'h00) begin
        out_next.data = in_i.data;
      end else begin
        out_next.data = mem_reg[wptr_reg - delay_i];
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= 16'sh0000;
      end
      wptr_reg <= 5'h00;
      out_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wptr_reg <= wptr_next;
      out_reg <= out_next;
    end
  end

  assign out_o = out_reg;
endmodule // drs_delay_line

// [rtl/drs_pkg.sv]
// Shared constants, register map and carrier types of the rail selector.
package drs_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned LEVEL_W = 15;
  localparam int unsigned DELAY_MAX = 32;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_THRESH = 8'h04;
  localparam logic [7:0] ADDR_BATT = 8'h08;
  localparam logic [7:0] ADDR_TIMING = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Control register field positions.
  localparam int unsigned CTRL_PATH_EN = 0;
  localparam int unsigned CTRL_NOBATT = 1;
  localparam int unsigned CTRL_MODE_LO = 4;
  localparam int unsigned CTRL_METH_LO = 8;

  // Supply modes and threshold methods.
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_HIGH = 2'h1;
  localparam logic [1:0] MODE_BATT = 2'h2;
  localparam logic [1:0] METH_FIXED = 2'h0;
  localparam logic [1:0] METH_BATT = 2'h1;
  localparam logic [1:0] METH_MIN = 2'h2;

  // Reset values.
  localparam logic [1:0] MODE_RST = MODE_AUTO;
  localparam logic [1:0] METH_RST = METH_BATT;
  localparam logic [14:0] FIXED_THR_RST = 15'h2000;
  localparam logic [14:0] HEADROOM_RST = 15'h0400;
  localparam logic [14:0] BATT_LOW_RST = 15'h1800;
  localparam logic [15:0] HOLD_RST = 16'h0100;
  localparam logic [4:0] DELAY_RST = 5'h08;

  // AHB-Lite transfer and size codes.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic speaker_path_enable;
    logic no_battery_supply;
    logic [1:0] amp_supply_mode;
    logic [1:0] switch_threshold_method;
    logic [14:0] fixed_switch_threshold;
    logic [14:0] battery_relative_headroom;
    logic [14:0] battery_low_level;
    logic [15:0] low_rail_hold_time;
    logic [4:0] signal_path_delay;
  } drs_cfg_t;

  typedef struct packed {
    logic valid;
    logic signed [15:0] data;
  } drs_sample_t;
endpackage

// [rtl/drs_rail_selector.sv]
// Top of the dual-rail supply selector with its audio delay path.
//
// Operation
// (R1) One enable bit turns the whole speaker playback path on or off.
// (R2) Automatic mode picks the high or battery rail from signal level.
// (R3) With automatic mode off, a fixed rail from the mode field is used.
// (R4) Mode 1: high rail with low-voltage output low; mode 2: battery, high.
// (R5) The supply mode field resets to automatic operation.
// (R6) Battery below its low level forces the high-voltage rail in auto mode.
// (R7) Method 0 uses the fixed threshold value.
// (R8) Method 1 uses measured battery voltage minus the headroom value.
// (R9) Method 2 uses the lower of the fixed and battery-relative thresholds.
// (R10) Battery rail only after level stays below threshold past hold time.
// (R11) After hold time expires, the switch waits for the next zero crossing.
// (R12) Low-voltage output is high while the battery rail is active.
// (R13) Level above threshold returns to the high-voltage rail at once.
// (R14) Low-voltage output is low while the high-voltage rail is active.
// (R15) Automatic mode delays the audio path by the programmed sample count.
// (R16) No-battery-supply bit forces the high-voltage rail, ignoring mode.
// (R17) Zero crossing is a sign change or zero sample, checked per sample.
// (R18) Any above-threshold sample restarts the hold counter.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module drs_rail_selector (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic sample_valid_i,
  input wire logic signed [15:0] sample_i,
  input wire logic [14:0] battery_voltage_i,
  output logic out_valid_o,
  output logic signed [15:0] out_sample_o,
  output logic low_voltage_enable_out_o,
  output logic amp_enable_o
);
  typedef enum logic [2:0] {
    ST_HIGH = 3'b001,
    ST_HOLD = 3'b010,
    ST_BATT = 3'b100
  } drs_state_t;

  drs_pkg::drs_cfg_t cfg;
  drs_pkg::drs_sample_t path_in;
  drs_pkg::drs_sample_t path_out;
  logic [3:0] status;

  drs_state_t state_reg;
  drs_state_t state_next;
  logic [15:0] hold_cnt_reg;
  logic [15:0] hold_cnt_next;
  logic prev_neg_reg;
  logic prev_neg_next;
  logic lv_reg;
  logic lv_next;
  logic en_reg;
  logic en_next;
  logic ovalid_reg;
  logic ovalid_next;
  logic signed [15:0] osample_reg;
  logic signed [15:0] osample_next;

  logic auto_mode;
  logic [14:0] thr_batt;
  logic [14:0] rail_switch_threshold;
  logic [14:0] level;
  logic above;
  logic zero_cross;
  logic force_high;

  // Magnitude saturates so the most negative sample does not wrap to zero.
  function automatic logic [14:0] magnitude(input logic signed [15:0] s);
    logic [15:0] m;
    m = s[15] ? 16'(-s) : 16'(s);
    return m[15] ? 15'h7fff : m[14:0];
  endfunction

  drs_ahb_regs u_regs (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hsize_i(hsize_i),
    .hwdata_i(hwdata_i),
    .hready_i(hready_i),
    .status_i(status),
    .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .cfg_o(cfg)
  );

  assign status = {state_reg == ST_HOLD, auto_mode, en_reg, lv_reg};

  // Delay applies only in automatic mode; fixed rails pass samples straight.
  always_comb begin
    path_in.valid = sample_valid_i && cfg.speaker_path_enable; // (R1)
    path_in.data = sample_i;
  end

  drs_delay_line #(
    .DEPTH(drs_pkg::DELAY_MAX)
  ) u_delay (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .delay_i(auto_mode ? cfg.signal_path_delay : 5'h00), // (R15)
    .in_i(path_in),
    .out_o(path_out)
  );

  assign auto_mode = !cfg.no_battery_supply &&
                     (cfg.amp_supply_mode == drs_pkg::MODE_AUTO); // (R2)

  // Battery-relative threshold clamps at zero when headroom exceeds battery.
  assign thr_batt = (battery_voltage_i > cfg.battery_relative_headroom) ?
    battery_voltage_i - cfg.battery_relative_headroom : 15'h0000; // (R8)

  always_comb begin
    case (cfg.switch_threshold_method)
      drs_pkg::METH_FIXED: rail_switch_threshold =
        cfg.fixed_switch_threshold; // (R7)
      drs_pkg::METH_BATT: rail_switch_threshold = thr_batt; // (R8)
      drs_pkg::METH_MIN: rail_switch_threshold =
        (thr_batt < cfg.fixed_switch_threshold) ?
        thr_batt : cfg.fixed_switch_threshold; // (R9)
      default: rail_switch_threshold = thr_batt;
    endcase
  end

  // The level is judged on the undelayed input so the rail leads the audio.
  assign level = magnitude(sample_i);
  assign above = level > rail_switch_threshold;
  assign zero_cross = (sample_i == 16'sh0000) ||
                      (sample_i[15] != prev_neg_reg); // (R17)
  assign force_high = battery_voltage_i < cfg.battery_low_level; // (R6)

  always_comb begin
    state_next = state_reg;
    hold_cnt_next = hold_cnt_reg;
    prev_neg_next = prev_neg_reg;
    if (sample_valid_i) begin
      prev_neg_next = sample_i[15]; // (R17)
    end
    if (!auto_mode || force_high) begin
      state_next = ST_HIGH; // (R3) (R6) (R16)
      hold_cnt_next = 16'h0000;
    end else if (sample_valid_i) begin
      case (state_reg)
        ST_HIGH: begin
          if (above) begin
            hold_cnt_next = 16'h0000; // (R18)
          end else if (hold_cnt_reg >= cfg.low_rail_hold_time) begin
            state_next = ST_HOLD; // (R10)
          end else begin
            hold_cnt_next = hold_cnt_reg + 16'h0001;
          end
        end
        ST_HOLD: begin
          if (above) begin
            state_next = ST_HIGH; // (R18)
            hold_cnt_next = 16'h0000;
          end else if (zero_cross) begin
            state_next = ST_BATT; // (R11)
          end
        end
        ST_BATT: begin
          if (above) begin
            state_next = ST_HIGH; // (R13)
            hold_cnt_next = 16'h0000;
          end
        end
        default: begin
          state_next = ST_HIGH;
          hold_cnt_next = 16'h0000;
        end
      endcase
    end
  end

  always_comb begin
    en_next = cfg.speaker_path_enable; // (R1)
    ovalid_next = path_out.valid;
    osample_next = path_out.data;
    if (cfg.no_battery_supply) begin
      lv_next = 1'b0; // (R16)
    end else if (cfg.amp_supply_mode == drs_pkg::MODE_BATT) begin
      lv_next = 1'b1; // (R4)
    end else if (cfg.amp_supply_mode == drs_pkg::MODE_HIGH) begin
      lv_next = 1'b0; // (R4)
    end else if (cfg.amp_supply_mode == drs_pkg::MODE_AUTO) begin
      lv_next = (state_next == ST_BATT); // (R12) (R14)
    end else begin
      lv_next = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_HIGH;
      hold_cnt_reg <= 16'h0000;
      prev_neg_reg <= 1'b0;
      lv_reg <= 1'b0;
      en_reg <= 1'b0;
      ovalid_reg <= 1'b0;
      osample_reg <= 16'sh0000;
    end else begin
      state_reg <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      prev_neg_reg <= prev_neg_next;
      lv_reg <= lv_next;
      en_reg <= en_next;
      ovalid_reg <= ovalid_next;
      osample_reg <= osample_next;
    end
  end

  assign low_voltage_enable_out_o = lv_reg;
  assign amp_enable_o = en_reg;
  assign out_valid_o = ovalid_reg;
  assign out_sample_o = osample_reg;
endmodule // drs_rail_selector
